// ==== hdl/lpgd_cfg.svh ====
// register map, reset values, select codes and timing counts
`ifndef LPGD_CFG_SVH
`define LPGD_CFG_SVH

`define LPGD_REG_CTRL        8'h00
`define LPGD_REG_GRP_DUTY    8'h04
`define LPGD_REG_BLINK_PER   8'h08
`define LPGD_REG_STATE_SEL   8'h0c
`define LPGD_REG_DUTY0       8'h10
`define LPGD_REG_DUTY7       8'h2c
`define LPGD_REG_RX_DATA     8'h30
`define LPGD_REG_TX_DATA     8'h34
`define LPGD_REG_STATUS      8'h38

`define LPGD_RESP_OKAY       2'b00
`define LPGD_RESP_SLVERR     2'b10

`define LPGD_RST_GRP_MODE    1'b0
`define LPGD_RST_GRP_DUTY    8'hff
`define LPGD_RST_BLINK_PER   8'h00
`define LPGD_RST_STATE_SEL   16'h0000
`define LPGD_RST_IND_DUTY    8'h00
`define LPGD_RST_TX_DATA     8'h00

`define LPGD_SEL_OFF         2'b00
`define LPGD_SEL_ON          2'b01
`define LPGD_SEL_IND         2'b10
`define LPGD_SEL_GROUP       2'b11

`define LPGD_BITS_PER_BYTE   4'h8
`define LPGD_LAST_BIT        4'h7
`define LPGD_CHANNELS        8
`define LPGD_FIFO_DEPTH      8
`define LPGD_BYTE_W          8

`define LPGD_CLK_HZ          20000000
`define LPGD_CLK_NS          50
`define LPGD_IND_STEP_NS     40
`define LPGD_IND_STEP_CYC    \
  ((`LPGD_IND_STEP_NS + `LPGD_CLK_NS - 1) / `LPGD_CLK_NS)
`define LPGD_IND_STEPS       256
`define LPGD_GRP_STEP_NS     20480
`define LPGD_GRP_PULSES      \
  (`LPGD_GRP_STEP_NS / (`LPGD_IND_STEP_NS * `LPGD_IND_STEPS))
`define LPGD_BLINK_MAX_MS    10730
`define LPGD_BLINK_STEP_CYC  \
  ((`LPGD_BLINK_MAX_MS * (`LPGD_CLK_HZ / 1000)) / 65536)

`endif

// ==== hdl/lpgd_pkg.sv ====
// types shared by the led pwm block
package lpgd_pkg;
  typedef logic [7:0]  lpgd_byte_t;
  typedef logic [7:0]  lpgd_addr_t;
  typedef logic [31:0] lpgd_word_t;
  typedef logic [1:0]  lpgd_sel_t;

  typedef enum logic [2:0] {
    st_idle,
    st_rx,
    st_ack,
    st_tx,
    st_txack
  } lpgd_i2c_state_t;

  typedef enum logic {
    grp_dim,
    grp_blink
  } lpgd_group_mode_t;
endpackage

// ==== hdl/lpgd_fifo.sv ====
// byte fifo with registered head word between serial receiver and bus
`timescale 1ns/10ps
`default_nettype none
module lpgd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW-1:0]    wr_ptr_inc;
  logic [AW-1:0]    rd_ptr_inc;
  logic [CW-1:0]    count;
  logic             push;
  logic             pop;
  logic             head_from_in;

  assign in_ready     = (count != CW'(DEPTH));
  assign out_valid    = (count != '0);
  assign push         = in_valid & in_ready;
  assign pop          = out_valid & out_ready;
  assign wr_ptr_inc   = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
  assign rd_ptr_inc   = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
  assign head_from_in = push & ((count == '0) | (pop & (count == CW'(1))));

  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr_inc;
      end
      if (pop) begin
        rd_ptr <= rd_ptr_inc;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
    end else if (push && !pop) begin
      count <= count + 1'b1;
    end else if (pop && !push) begin
      count <= count - 1'b1;
    end
  end

  // head word register keeps the oldest entry ready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_data <= '0;
    end else if (head_from_in) begin
      out_data <= in_data;
    end else if (pop) begin
      out_data <= mem[rd_ptr_inc];
    end
  end
endmodule // lpgd_fifo
`default_nettype wire

// ==== hdl/lpgd_led_pwm.sv ====
// led brightness pwm with group dim/blink, serial slave and axi4-lite regs
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "lpgd_cfg.svh"
module lpgd_led_pwm (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire lpgd_pkg::lpgd_addr_t awaddr,
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire lpgd_pkg::lpgd_word_t wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output logic                      wready,
  output logic [1:0]                bresp,
  output logic                      bvalid,
  input  wire logic                 bready,
  input  wire lpgd_pkg::lpgd_addr_t araddr,
  input  wire logic                 arvalid,
  output logic                      arready,
  output var lpgd_pkg::lpgd_word_t  rdata,
  output logic [1:0]                rresp,
  output logic                      rvalid,
  input  wire logic                 rready,
  input  wire logic                 scl_in,
  input  wire logic                 sda_in,
  output logic                      sda_out,
  output logic                      sda_oe,
  output logic [7:0]                led_output_channel
);
  import lpgd_pkg::*;

  function automatic logic is_duty(input lpgd_addr_t a);
    return (a >= `LPGD_REG_DUTY0) && (a <= `LPGD_REG_DUTY7)
           && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [2:0] duty_idx(input lpgd_addr_t a);
    lpgd_addr_t off;
    off = a - `LPGD_REG_DUTY0;
    return off[4:2];
  endfunction

  function automatic logic is_mapped(input lpgd_addr_t a);
    return is_duty(a) || a == `LPGD_REG_CTRL || a == `LPGD_REG_GRP_DUTY
           || a == `LPGD_REG_BLINK_PER || a == `LPGD_REG_STATE_SEL
           || a == `LPGD_REG_RX_DATA || a == `LPGD_REG_TX_DATA
           || a == `LPGD_REG_STATUS;
  endfunction

  function automatic logic chan_level(input lpgd_sel_t sel,
                                      input logic ind, input logic grp);
    case (sel)
      `LPGD_SEL_OFF:   return 1'b0;
      `LPGD_SEL_ON:    return 1'b1;
      `LPGD_SEL_IND:   return ind;
      default:         return ind & grp;
    endcase
  endfunction

  // settings
  lpgd_group_mode_t group_mode;
  lpgd_byte_t       group_duty_value;
  lpgd_byte_t       blink_period;
  logic [15:0]      output_state_select;
  lpgd_byte_t       individual_duty_value [`LPGD_CHANNELS];
  lpgd_byte_t       tx_byte;

  // bus slave state
  logic             aw_held;
  logic             w_held;
  lpgd_addr_t       aw_addr_q;
  lpgd_word_t       w_data_q;
  logic [3:0]       w_strb_q;
  logic             do_write;
  logic             ar_hs;
  lpgd_word_t       rd_word;

  // serial side
  logic [1:0]       scl_sync;
  logic [1:0]       sda_sync;
  logic             scl_prev;
  logic             sda_prev;
  logic             scl_rise;
  logic             scl_fall;
  logic             start_cond;
  logic             stop_cond;
  lpgd_i2c_state_t  i2c_state;
  logic [3:0]       bit_cnt;
  lpgd_byte_t       shift;
  logic             first_byte;
  logic             read_dir;
  logic             sda_drive;
  logic             bus_busy;
  logic             last_nack;
  logic             ack_byte;
  logic             push_valid;

  // fifo
  logic             fifo_in_ready;
  logic             fifo_out_valid;
  logic             fifo_out_ready;
  lpgd_byte_t       fifo_out_data;

  // pwm timing
  logic [3:0]       ind_pre;
  lpgd_byte_t       ind_cnt;
  logic [1:0]       grp_pulse;
  lpgd_byte_t       dim_phase;
  logic [11:0]      blink_pre;
  lpgd_byte_t       blink_rep;
  lpgd_byte_t       blink_phase;
  logic             ind_tick;
  logic             ind_wrap;
  logic             grp_tick;
  logic             blink_sub;
  logic             blink_adv;
  logic             group_gate;
  logic [7:0]       next_led;

  // axi4-lite write channel
  assign awready  = !aw_held && !bvalid;
  assign wready   = !w_held && !bvalid;
  assign do_write = aw_held && w_held && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      bvalid    <= 1'b0;
      bresp     <= `LPGD_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held   <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_held   <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= is_mapped(aw_addr_q) ? `LPGD_RESP_OKAY
                                        : `LPGD_RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      group_mode          <= lpgd_group_mode_t'(`LPGD_RST_GRP_MODE);
      group_duty_value    <= `LPGD_RST_GRP_DUTY;
      blink_period        <= `LPGD_RST_BLINK_PER;
      output_state_select <= `LPGD_RST_STATE_SEL;
      tx_byte             <= `LPGD_RST_TX_DATA;
      for (int i = 0; i < `LPGD_CHANNELS; i++) begin
        individual_duty_value[i] <= `LPGD_RST_IND_DUTY;
      end
    end else if (do_write && w_strb_q[0]) begin
      if (aw_addr_q == `LPGD_REG_CTRL) begin
        group_mode <= lpgd_group_mode_t'(w_data_q[0]);
      end
      if (aw_addr_q == `LPGD_REG_GRP_DUTY) begin
        group_duty_value <= w_data_q[7:0];
      end
      if (aw_addr_q == `LPGD_REG_BLINK_PER) begin
        blink_period <= w_data_q[7:0];
      end
      if (aw_addr_q == `LPGD_REG_TX_DATA) begin
        tx_byte <= w_data_q[7:0];
      end
      if (aw_addr_q == `LPGD_REG_STATE_SEL) begin
        output_state_select[7:0] <= w_data_q[7:0];
      end
      if (is_duty(aw_addr_q)) begin
        individual_duty_value[duty_idx(aw_addr_q)] <= w_data_q[7:0];
      end
    end
    if (aresetn && do_write && w_strb_q[1]
        && aw_addr_q == `LPGD_REG_STATE_SEL) begin
      output_state_select[15:8] <= w_data_q[15:8];
    end
  end

  // axi4-lite read channel; reading rx data pops the fifo
  assign arready        = !rvalid;
  assign ar_hs          = arvalid && arready;
  assign fifo_out_ready = ar_hs && (araddr == `LPGD_REG_RX_DATA);
  assign rd_word =
    (araddr == `LPGD_REG_CTRL)      ? {31'h0, group_mode} :
    (araddr == `LPGD_REG_GRP_DUTY)  ? {24'h0, group_duty_value} :
    (araddr == `LPGD_REG_BLINK_PER) ? {24'h0, blink_period} :
    (araddr == `LPGD_REG_STATE_SEL) ? {16'h0, output_state_select} :
    (araddr == `LPGD_REG_TX_DATA)   ? {24'h0, tx_byte} :
    (araddr == `LPGD_REG_RX_DATA)   ? {23'h0, fifo_out_valid,
                                       fifo_out_data} :
    (araddr == `LPGD_REG_STATUS)    ? {28'h0, last_nack, !fifo_in_ready,
                                       !fifo_out_valid, bus_busy} :
    is_duty(araddr) ? {24'h0, individual_duty_value[duty_idx(araddr)]} :
    32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= `LPGD_RESP_OKAY;
    end else if (ar_hs) begin
      rvalid <= 1'b1;
      rdata  <= rd_word;
      rresp  <= is_mapped(araddr) ? `LPGD_RESP_OKAY : `LPGD_RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // serial line synchronisers and condition detect
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end

  assign scl_rise   = scl_sync[1] && !scl_prev;
  assign scl_fall   = !scl_sync[1] && scl_prev;
  assign start_cond = scl_sync[1] && scl_prev && sda_prev
                      && !sda_sync[1];
  assign stop_cond  = scl_sync[1] && scl_prev && !sda_prev
                      && sda_sync[1];
  assign ack_byte   = first_byte || fifo_in_ready;
  assign push_valid = (i2c_state == st_rx) && scl_fall && !first_byte
                      && (bit_cnt == `LPGD_BITS_PER_BYTE);
  assign sda_out    = 1'b0;
  assign sda_oe     = sda_drive;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      i2c_state  <= st_idle;
      bit_cnt    <= '0;
      shift      <= '0;
      first_byte <= 1'b0;
      read_dir   <= 1'b0;
      sda_drive  <= 1'b0;
      bus_busy   <= 1'b0;
      last_nack  <= 1'b0;
    end else if (start_cond) begin
      i2c_state  <= st_rx;
      bit_cnt    <= '0;
      first_byte <= 1'b1;
      sda_drive  <= 1'b0;
      bus_busy   <= 1'b1;
    end else if (stop_cond) begin
      i2c_state <= st_idle;
      sda_drive <= 1'b0;
      bus_busy  <= 1'b0;
    end else begin
      case (i2c_state)
        st_rx: begin
          if (scl_rise && bit_cnt != `LPGD_BITS_PER_BYTE) begin
            shift   <= {shift[6:0], sda_sync[1]};
            bit_cnt <= bit_cnt + 1'b1;
          end else if (scl_fall && bit_cnt == `LPGD_BITS_PER_BYTE) begin
            if (ack_byte) begin
              sda_drive <= 1'b1;
              i2c_state <= st_ack;
              if (first_byte) begin
                read_dir <= shift[0];
              end
            end else begin
              i2c_state <= st_idle;
            end
          end
        end
        st_ack: begin
          if (scl_fall) begin
            first_byte <= 1'b0;
            bit_cnt    <= '0;
            if (read_dir) begin
              i2c_state <= st_tx;
              shift     <= tx_byte;
              sda_drive <= !tx_byte[7];
            end else begin
              i2c_state <= st_rx;
              sda_drive <= 1'b0;
            end
          end
        end
        st_tx: begin
          if (scl_fall) begin
            if (bit_cnt == `LPGD_LAST_BIT) begin
              sda_drive <= 1'b0;
              i2c_state <= st_txack;
            end else begin
              sda_drive <= !shift[6];
              shift     <= {shift[6:0], 1'b0};
              bit_cnt   <= bit_cnt + 1'b1;
            end
          end
        end
        st_txack: begin
          if (scl_rise) begin
            last_nack <= sda_sync[1];
            if (sda_sync[1]) begin
              i2c_state <= st_idle;
            end
          end else if (scl_fall) begin
            i2c_state <= st_tx;
            bit_cnt   <= '0;
            shift     <= tx_byte;
            sda_drive <= !tx_byte[7];
          end
        end
        default: begin
          i2c_state <= st_idle;
        end
      endcase
    end
  end

  lpgd_fifo #(
    .WIDTH (`LPGD_BYTE_W),
    .DEPTH (`LPGD_FIFO_DEPTH)
  ) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (push_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (shift),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // pwm time base
  assign ind_tick   = (ind_pre == 4'(`LPGD_IND_STEP_CYC - 1));
  assign ind_wrap   = ind_tick && (ind_cnt == 8'hff);
  assign grp_tick   = ind_wrap
                      && (grp_pulse == 2'(`LPGD_GRP_PULSES - 1));
  assign blink_sub  = (blink_pre == 12'(`LPGD_BLINK_STEP_CYC - 1));
  assign blink_adv  = blink_sub && (blink_rep == blink_period);
  assign group_gate = (group_mode == grp_blink)
                      ? (blink_phase < group_duty_value)
                      : (dim_phase < group_duty_value);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ind_pre     <= '0;
      ind_cnt     <= '0;
      grp_pulse   <= '0;
      dim_phase   <= '0;
      blink_pre   <= '0;
      blink_rep   <= '0;
      blink_phase <= '0;
    end else begin
      ind_pre <= ind_tick ? 4'h0 : ind_pre + 1'b1;
      if (ind_tick) begin
        ind_cnt <= ind_cnt + 1'b1;
      end
      if (ind_wrap) begin
        grp_pulse <= grp_tick ? 2'h0 : grp_pulse + 1'b1;
      end
      if (grp_tick) begin
        dim_phase <= dim_phase + 1'b1;
      end
      blink_pre <= blink_sub ? 12'h0 : blink_pre + 1'b1;
      if (blink_sub) begin
        blink_rep <= blink_adv ? 8'h0 : blink_rep + 1'b1;
      end
      if (blink_adv) begin
        blink_phase <= blink_phase + 1'b1;
      end
    end
  end

  // per-channel output selection
  for (genvar n = 0; n < `LPGD_CHANNELS; n++) begin : g_chan
    assign next_led[n] = chan_level(output_state_select[2*n +: 2],
                                    ind_cnt < individual_duty_value[n],
                                    group_gate);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      led_output_channel <= '0;
    end else begin
      led_output_channel <= next_led;
    end
  end
endmodule // lpgd_led_pwm
`default_nettype wire

// ==== verification/lpgd_checker.sv ====
// port assertions for the led pwm block
`timescale 1ns/10ps
`default_nettype none
module lpgd_checker (
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire logic                 awvalid,
  input wire logic                 awready,
  input wire logic                 wvalid,
  input wire logic                 wready,
  input wire logic [1:0]           bresp,
  input wire logic                 bvalid,
  input wire logic                 bready,
  input wire lpgd_pkg::lpgd_addr_t araddr,
  input wire logic                 arvalid,
  input wire logic                 arready,
  input wire lpgd_pkg::lpgd_word_t rdata,
  input wire logic [1:0]           rresp,
  input wire logic                 rvalid,
  input wire logic                 rready,
  input wire logic                 scl_in,
  input wire logic                 sda_oe,
  input wire logic [7:0]           led_output_channel
);
  import lpgd_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_rst_off: assert property (disable iff (1'b0)
    !aresetn |=> led_output_channel == 8'h00 && !sda_oe)
    else $error("outputs not cleared by reset");
  a_b_hold: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_r_hold: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read response dropped early");
  a_w_block: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while response pending");
  a_ar_block: assert property (rvalid |-> !arready)
    else $error("read accepted while data pending");
  a_w_resp: assert property (
    awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response not after two cycles");
  a_r_resp: assert property (arvalid && arready |=> rvalid)
    else $error("read data not after one cycle");
  a_r_err: assert property (
    arvalid && arready && araddr > 8'h38 |=> rresp == 2'b10 && rdata == 0)
    else $error("unmapped read not refused");
  a_ack_steady: assert property (
    sda_oe && scl_in ##1 scl_in |-> sda_oe)
    else $error("data released while serial clock high");
  c_write: cover property (bvalid && bready);
  c_rd_err: cover property (rvalid && rready && rresp == 2'b10);
  c_ack: cover property ($rose(sda_oe));
endmodule // lpgd_checker

bind lpgd_led_pwm lpgd_checker u_chk (.aclk(aclk), .aresetn(aresetn),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
  .rvalid(rvalid), .rready(rready), .scl_in(scl_in), .sda_oe(sda_oe),
  .led_output_channel(led_output_channel));
`default_nettype wire

// ==== verification/lpgd_i2c_master.sv ====
// serial bus master model, 400 ns bit period
`timescale 1ns/10ps
`default_nettype none
module lpgd_i2c_master (
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic start();
    #13 sda_drv = 1'b0;
    #200 scl = 1'b0;
  endtask
  task automatic stop();
    #20 sda_drv = 1'b0;
    #80 scl = 1'b1;
    #200 sda_drv = 1'b1;
    #200;
  endtask
  task automatic bit_io(input logic b, output logic r);
    #20 sda_drv = b;
    #80 scl = 1'b1;
    #100 r = sda;
    #100 scl = 1'b0;
    #100;
  endtask
  task automatic xfer(input logic [7:0] d, input logic ack_in,
                      output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ack_in, ack);
  endtask
endmodule // lpgd_i2c_master
`default_nettype wire

// ==== verification/testbench.sv ====
// self-checking bench for the led pwm block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import lpgd_pkg::*;
  logic       aclk = 1'b0;
  logic       aresetn = 1'b0;
  lpgd_addr_t awaddr = '0;
  lpgd_addr_t araddr = '0;
  lpgd_word_t wdata = '0;
  lpgd_word_t rdata;
  logic [3:0] wstrb = 4'h0;
  logic       awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic       arvalid = 1'b0, rready = 1'b0;
  logic       awready, wready, bvalid, arready, rvalid, sda_out, sda_oe;
  logic [1:0] bresp, rresp;
  logic [7:0] led_output_channel;
  logic       scl, sda_drv;
  wire logic  sda;
  int         n_errors = 0;
  int         checks = 0;
  logic [1:0] q_b[$];
  logic [33:0] q_r[$];
  assign sda = (sda_oe ? sda_out : 1'b1) & sda_drv;
  lpgd_led_pwm u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .led_output_channel(led_output_channel));
  lpgd_i2c_master u_mst (.scl(scl), .sda_drv(sda_drv), .sda(sda));
  always #25 aclk = ~aclk;
  task automatic stop_test();
    if (n_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [33:0] e,
                     input logic [33:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic hang();
    n_errors++;
    stop_test();
  endtask
  task automatic wr(input lpgd_addr_t a, input lpgd_word_t d,
                    input logic [1:0] r);
    int n;
    logic ta, tw, tb;
    q_b.push_back(r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) begin
        bready <= 1'b0;
        break;
      end
    end
    if (n == 50) hang();
  endtask
  task automatic rd(input lpgd_addr_t a, input lpgd_word_t d,
                    input logic [1:0] r);
    int n;
    logic ta, tr;
    q_r.push_back({r, d});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      ta = arvalid & arready;
      tr = rvalid;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) begin
        rready <= 1'b0;
        break;
      end
    end
    if (n == 50) hang();
  endtask
  task automatic led_cnt(input int ch, input int e);
    int c;
    c = 0;
    repeat (2) @(negedge aclk);
    repeat (256) begin
      @(negedge aclk);
      if (led_output_channel[ch] === 1'b1) c++;
    end
    chk("led_count", 34'(e), 34'(c));
  endtask
  always @(posedge aclk) begin
    if (bvalid && bready && q_b.size() > 0)
      chk("bresp", 34'(q_b.pop_front()), 34'(bresp));
    if (rvalid && rready && q_r.size() > 0)
      chk("rresp_rdata", q_r.pop_front(), {rresp, rdata});
  end
  initial begin
    lpgd_word_t d;
    logic [7:0] b, q;
    logic [7:0] v[8];
    logic ak;
    void'($urandom(76));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk("led_rst", 34'h0, 34'(led_output_channel));
    rd(8'h00, 32'h0, 2'b00);
    rd(8'h04, 32'hff, 2'b00);
    rd(8'h08, 32'h0, 2'b00);
    rd(8'h0c, 32'h0, 2'b00);
    for (int i = 0; i < 8; i++) rd(8'h10 + 8'(4 * i), 32'h0, 2'b00);
    rd(8'h34, 32'h0, 2'b00);
    rd(8'h38, 32'h2, 2'b00);
    rd(8'h3c, 32'h0, 2'b10);
    wr(8'h40, 32'h1, 2'b10);
    for (int i = 0; i < 8; i++) begin
      d = $urandom();
      v[i] = d[7:0];
      wr(8'h10 + 8'(4 * i), d, 2'b00);
      rd(8'h10 + 8'(4 * i), {24'h0, d[7:0]}, 2'b00);
    end
    wr(8'h0c, 32'h0000aae1, 2'b00);
    rd(8'h0c, 32'h0000aae1, 2'b00);
    led_cnt(0, 256);
    led_cnt(1, 0);
    led_cnt(2, int'(v[2]));
    led_cnt(3, int'(v[3]));
    wr(8'h04, 32'h0, 2'b00);
    led_cnt(3, 0);
    led_cnt(2, int'(v[2]));
    wr(8'h00, 32'h1, 2'b00);
    wr(8'h04, 32'hff, 2'b00);
    b = 8'($urandom());
    wr(8'h08, {24'h0, b}, 2'b00);
    rd(8'h08, {24'h0, b}, 2'b00);
    rd(8'h00, 32'h1, 2'b00);
    led_cnt(3, int'(v[3]));
    u_mst.start();
    u_mst.xfer(8'h00, 1'b1, q, ak);
    chk("dir_ack", 34'h0, 34'(ak));
    for (int i = 0; i < 9; i++) begin
      b = 8'($urandom());
      if (i < 8) v[i] = b;
      u_mst.xfer(b, 1'b1, q, ak);
      chk("wr_ack", 34'(i == 8), 34'(ak));
    end
    u_mst.stop();
    for (int i = 0; i < 8; i++) rd(8'h30, {23'h0, 1'b1, v[i]}, 2'b00);
    b = 8'($urandom());
    wr(8'h34, {24'h0, b}, 2'b00);
    u_mst.start();
    u_mst.xfer(8'h01, 1'b1, q, ak);
    chk("dir_ack", 34'h0, 34'(ak));
    u_mst.xfer(8'hff, 1'b0, q, ak);
    chk("rd_byte", 34'(b), 34'(q));
    u_mst.xfer(8'hff, 1'b1, q, ak);
    chk("rd_last", 34'(b), 34'(q));
    u_mst.stop();
    rd(8'h38, 32'ha, 2'b00);
    stop_test();
  end
endmodule // testbench
`default_nettype wire
